// File: rtl/pmcr_consts.svh
// register offsets, reset values and timing counts of the paged command bank
`ifndef PMCR_CONSTS_SVH
`define PMCR_CONSTS_SVH
`define PMCR_OFS_SLEW        8'h27
`define PMCR_OFS_CAL_GAIN    8'h38
`define PMCR_OFS_UV_FAULT    8'h44
`define PMCR_OFS_OC_FAULT    8'h46
`define PMCR_OFS_OC_WARN     8'h4A
`define PMCR_OFS_TON_DLY     8'h60
`define PMCR_OFS_TURN_ON_RISE_TIME    8'h61
`define PMCR_OFS_TON_MAX     8'h62
`define PMCR_OFS_TOFF_DLY    8'h64
`define PMCR_OFS_TURN_OFF_FALL_TIME   8'h65
`define PMCR_OFS_TOFF_MAX    8'h66
`define PMCR_OFS_RESTART     8'hDC
`define PMCR_OFS_OFFSET_RB   8'hE8
`define PMCR_OFS_LSE         8'hF7
`define PMCR_RST_SLEW        16'h82BF
`define PMCR_RST_CAL_GAIN    16'hCA80
`define PMCR_RST_UV_FAULT    16'h05C3
`define PMCR_RST_OC_FAULT    16'hDBB8
`define PMCR_RST_OC_WARN     16'hDA80
`define PMCR_RST_TON_DLY     16'h8000
`define PMCR_RST_TURN_ON_RISE_TIME    16'hD200
`define PMCR_RST_TON_MAX     16'hD280
`define PMCR_RST_TOFF_DLY    16'h8000
`define PMCR_RST_TURN_OFF_FALL_TIME   16'hD200
`define PMCR_RST_TOFF_MAX    16'h8000
`define PMCR_RST_RESTART     16'hFBE8
`define PMCR_RST_LSE         8'h00
`define PMCR_LSE_TRIG_BIT    3
`define PMCR_LSE_MODE_BIT    2
`define PMCR_CLK_MHZ         50
`define PMCR_LSE_PULSE_US    100
`define PMCR_LSE_PULSE_CYC   (`PMCR_LSE_PULSE_US * `PMCR_CLK_MHZ)
`define PMCR_MS_CYC          (1000 * `PMCR_CLK_MHZ)
`define PMCR_NUM_CMD         13
`endif

// File: rtl/pmcr_pkg.sv
// types of the paged command bank
package pmcr_pkg;
   typedef enum logic [2:0] {
      PH_OFF,
      PH_RESTART,
      PH_ON_DLY,
      PH_RISE,
      PH_ON,
      PH_OFF_DLY,
      PH_FALL
   } pmcr_phase_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  code;
      logic [15:0] data;
   } pmcr_cmd_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
      logic        cml_fault;
   } pmcr_rsp_t;

   typedef struct packed {
      logic       lse_active;
      logic [1:0] lse_mag;
      logic       lse_trigger;
   } pmcr_lse_t;

   typedef struct packed {
      logic       oc_fault;
      logic       oc_warn;
      logic       iout_status_word;
      logic       uv_trip;
      logic       ton_max_fault;
      logic       toff_max_warn;
      logic       alert;
   } pmcr_flags_t;

   typedef struct packed {
      logic [1:0][12:0][15:0] regs;
      pmcr_phase_t [1:0]      phase;
      logic [1:0][31:0]       tmr;
      logic [1:0][31:0]       mon;
      logic [1:0]             mon_on;
      logic [1:0]             run_q;
      logic [1:0]             pg_q;
      logic [1:0][15:0]       lse_cnt;
      logic [1:0]             lse_pulse;
      pmcr_lse_t [1:0]        load_step_emulation;
      pmcr_flags_t [1:0]      flags;
      pmcr_rsp_t              rsp;
      logic [1:0]             run_hold;
      logic [1:0]             ramping;
   } pmcr_state_t;
endpackage

// File: rtl/pmcr_bank.sv
// paged pmbus command bank: limits, load step emulation and turn-on/off timing
`timescale 1ns/100ps
`include "pmcr_consts.svh"

module pmcr_bank
(
   input  wire logic                     core_clk_in,
   input  wire logic                     nrst_in,
   input  wire logic                     page_in,
   input  wire pmcr_pkg::pmcr_cmd_t      cmd_in,
   input  wire logic [1:0]               run_pin_in,
   input  wire logic [1:0]               op_on_in,
   input  wire logic [1:0][15:0]         vout_sense_in,
   input  wire logic [1:0][15:0]         vout_setpoint_in,
   input  wire logic [1:0][15:0]         iout_phase_in,
   input  wire logic [1:0][15:0]         iout_avg_in,
   input  wire logic [1:0]               power_good_in,
   input  wire logic [1:0][7:0]          serial_offset_code_in,
   input  wire logic [1:0]               alert_mask_in,
   input  wire logic [1:0]               status_clear_in,
   output logic                          rsp_valid_out,
   output logic [15:0]                   rsp_data_out,
   output logic                          cml_fault_out,
   output logic [1:0]                    run_pull_low_out,
   output logic [1:0]                    ramping_out,
   output logic [1:0]                    output_enable_out,
   output pmcr_pkg::pmcr_lse_t [1:0]     lse_out,
   output pmcr_pkg::pmcr_flags_t [1:0]   flags_out
);

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // map a command code onto a storage slot; 4'hF means not stored here
   // slot 4'hC holds the byte-wide emulation control
   function automatic logic [3:0] slot_of(input logic [7:0] code);
      unique case (code)
         `PMCR_OFS_SLEW:      slot_of = 4'h0;
         `PMCR_OFS_CAL_GAIN:  slot_of = 4'h1;
         `PMCR_OFS_UV_FAULT:  slot_of = 4'h2;
         `PMCR_OFS_OC_FAULT:  slot_of = 4'h3;
         `PMCR_OFS_OC_WARN:   slot_of = 4'h4;
         `PMCR_OFS_TON_DLY:   slot_of = 4'h5;
         `PMCR_OFS_TURN_ON_RISE_TIME:  slot_of = 4'h6;
         `PMCR_OFS_TON_MAX:   slot_of = 4'h7;
         `PMCR_OFS_TOFF_DLY:  slot_of = 4'h8;
         `PMCR_OFS_TURN_OFF_FALL_TIME: slot_of = 4'h9;
         `PMCR_OFS_TOFF_MAX:  slot_of = 4'hA;
         `PMCR_OFS_RESTART:   slot_of = 4'hB;
         `PMCR_OFS_LSE:       slot_of = 4'hC;
         default:             slot_of = 4'hF;
      endcase
   endfunction

   // linear 5s/11s milliseconds to clock cycles; negative exponent shifts right
   // exponent is the top five bits, two's complement
   // mantissa is taken unsigned: a negative time means nothing here
   // one millisecond is a fixed number of core clock cycles
   function automatic logic [31:0] ms_cycles(input logic [15:0] l11);
      logic signed [4:0] ex;
      logic [31:0]       mant;
      ex   = l11[15:11];
      mant = {21'h000000, l11[10:0]} * 32'(`PMCR_MS_CYC);
      if (ex < 0)
         ms_cycles = mant >> (-ex);
      else
         ms_cycles = mant << ex;
   endfunction

   // linear 11 value reduced to an integer magnitude for comparison
   function automatic logic [15:0] l11_int(input logic [15:0] l11);
      logic signed [4:0] ex;
      ex = l11[15:11];
      if (ex < 0)
         l11_int = {5'h00, l11[10:0]} >> (-ex);
      else
         l11_int = {5'h00, l11[10:0]} << ex;
   endfunction

   // default contents of one storage slot, same for both channel copies
   function automatic logic [15:0] reset_of(input int unsigned s);
      unique case (s)
         0:       reset_of = `PMCR_RST_SLEW;
         1:       reset_of = `PMCR_RST_CAL_GAIN;
         2:       reset_of = `PMCR_RST_UV_FAULT;
         3:       reset_of = `PMCR_RST_OC_FAULT;
         4:       reset_of = `PMCR_RST_OC_WARN;
         5:       reset_of = `PMCR_RST_TON_DLY;
         6:       reset_of = `PMCR_RST_TURN_ON_RISE_TIME;
         7:       reset_of = `PMCR_RST_TON_MAX;
         8:       reset_of = `PMCR_RST_TOFF_DLY;
         9:       reset_of = `PMCR_RST_TURN_OFF_FALL_TIME;
         10:      reset_of = `PMCR_RST_TOFF_MAX;
         11:      reset_of = `PMCR_RST_RESTART;
         default: reset_of = {8'h00, `PMCR_RST_LSE};
      endcase
   endfunction

   pmcr_pkg::pmcr_state_t st_r;
   pmcr_pkg::pmcr_state_t st_nxt;

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb
   begin
      logic [3:0]  sl;
      logic        pg;
      logic        want_on;
      logic        run_fall;
      logic [15:0] eighth;
      sl       = slot_of(cmd_in.code);
      pg       = page_in;
      want_on  = 1'b0;
      run_fall = 1'b0;
      eighth   = 16'h0000;
      st_nxt   = st_r;
      st_nxt.rsp = '0;

      // host access, page picks the copy
      if (cmd_in.wr && cmd_in.code != `PMCR_OFS_OFFSET_RB && sl != 4'hF)
      begin
         st_nxt.regs[pg][sl] = cmd_in.data;
         if (sl == 4'hC)
            st_nxt.regs[pg][sl] = {8'h00, cmd_in.data[7:0]};
         // gain change under a live rail corrupts current scaling
         if (sl == 4'h1 && (st_r.phase[0] != pmcr_pkg::PH_OFF ||
                            st_r.phase[1] != pmcr_pkg::PH_OFF))
            st_nxt.rsp.cml_fault = 1'b1;
      end
      // read-only or unmapped code: nothing stored, fault pulse instead
      else if (cmd_in.wr)
         st_nxt.rsp.cml_fault = 1'b1;
      // the answer stands for exactly one cycle after the taking edge
      if (cmd_in.rd)
      begin
         st_nxt.rsp.valid = 1'b1;
         if (cmd_in.code == `PMCR_OFS_OFFSET_RB)
            st_nxt.rsp.data = {8'h00, serial_offset_code_in[pg]};
         else if (sl != 4'hF)
            st_nxt.rsp.data = st_r.regs[pg][sl];
         // unknown read: zero data with the fault pulse
         else
            st_nxt.rsp.cml_fault = 1'b1;
      end

      for (int c = 0; c < 2; c++)
      begin
         // load step emulation, per master channel across its phases
         st_nxt.pg_q[c] = power_good_in[c];
         // trigger fires once per power good fall, only while armed
         st_nxt.load_step_emulation[c].lse_trigger = st_r.regs[c][12][`PMCR_LSE_TRIG_BIT] &&
                                     st_r.pg_q[c] && !power_good_in[c];
         // a nonzero rewrite during a pulse restarts it rather than stacking
         if (cmd_in.wr && pg == c && sl == 4'hC && cmd_in.data[1:0] != 2'b00 &&
             cmd_in.data[`PMCR_LSE_MODE_BIT])
         begin
            st_nxt.lse_cnt[c]   = 16'(`PMCR_LSE_PULSE_CYC);
            st_nxt.lse_pulse[c] = 1'b1;
         end
         else if (st_r.lse_cnt[c] > 16'h0001)
            st_nxt.lse_cnt[c] = st_r.lse_cnt[c] - 16'h0001;
         else
         begin
            st_nxt.lse_cnt[c]   = 16'h0000;
            st_nxt.lse_pulse[c] = 1'b0;
         end
         // static mode needs no counter: the level follows the stored bits
         if (st_r.regs[c][12][`PMCR_LSE_MODE_BIT])
            st_nxt.load_step_emulation[c].lse_active = st_r.lse_pulse[c];
         else
            st_nxt.load_step_emulation[c].lse_active = st_r.regs[c][12][1:0] != 2'b00;
         st_nxt.load_step_emulation[c].lse_mag = st_r.regs[c][12][1:0];

         // sequencing
         // power is wanted only with both run and operation on
         want_on  = run_pin_in[c] && op_on_in[c];
         st_nxt.run_q[c] = run_pin_in[c];
         run_fall = st_r.run_q[c] && !run_pin_in[c];
         // one timer per channel, cleared on every timed phase entry
         st_nxt.tmr[c] = st_r.tmr[c] + 32'h0000_0001;
         unique case (st_r.phase[c])
            pmcr_pkg::PH_OFF:
               if (run_fall)
               begin
                  st_nxt.phase[c] = pmcr_pkg::PH_RESTART;
                  st_nxt.tmr[c]   = '0;
               end
               else if (want_on)
               begin
                  st_nxt.phase[c] = pmcr_pkg::PH_ON_DLY;
                  st_nxt.tmr[c]   = '0;
               end

            // hold-off expiry returns to off; a new start needs a fresh request
            pmcr_pkg::PH_RESTART:
               if (st_r.tmr[c] >= ms_cycles(st_r.regs[c][11]))
                  st_nxt.phase[c] = pmcr_pkg::PH_OFF;

            pmcr_pkg::PH_ON_DLY:
               if (!want_on)
                  st_nxt.phase[c] = pmcr_pkg::PH_OFF;
               else if (st_r.tmr[c] >= ms_cycles(st_r.regs[c][5]))
               begin
                  st_nxt.phase[c] = pmcr_pkg::PH_RISE;
                  st_nxt.tmr[c]   = '0;
               end

            pmcr_pkg::PH_RISE:
               if (st_r.tmr[c] >= ms_cycles(st_r.regs[c][6]))
                  st_nxt.phase[c] = pmcr_pkg::PH_ON;

            pmcr_pkg::PH_ON:
               if (!want_on)
               begin
                  st_nxt.phase[c] = pmcr_pkg::PH_OFF_DLY;
                  st_nxt.tmr[c]   = '0;
               end

            pmcr_pkg::PH_OFF_DLY:
               if (st_r.tmr[c] >= ms_cycles(st_r.regs[c][8]))
               begin
                  st_nxt.phase[c] = pmcr_pkg::PH_FALL;
                  st_nxt.tmr[c]   = '0;
               end

            pmcr_pkg::PH_FALL:
               if (st_r.tmr[c] >= ms_cycles(st_r.regs[c][9]))
               begin
                  st_nxt.phase[c]  = run_pin_in[c] ? pmcr_pkg::PH_OFF : pmcr_pkg::PH_RESTART;
                  st_nxt.tmr[c]    = '0;
                  st_nxt.mon[c]    = '0;
                  st_nxt.mon_on[c] = 1'b1;
               end
         endcase
         st_nxt.run_hold[c] = st_nxt.phase[c] == pmcr_pkg::PH_RESTART;
         st_nxt.ramping[c]  = st_nxt.phase[c] == pmcr_pkg::PH_RISE ||
                              st_nxt.phase[c] == pmcr_pkg::PH_FALL;

         // supervisors; flags other than uv_trip and alert stick until cleared and a new event beats the clear
         st_nxt.flags[c].uv_trip = vout_sense_in[c] <= st_r.regs[c][2];
         if (status_clear_in[c])
         begin
            st_nxt.flags[c].oc_fault         = 1'b0;
            st_nxt.flags[c].oc_warn          = 1'b0;
            st_nxt.flags[c].iout_status_word = 1'b0;
            st_nxt.flags[c].ton_max_fault    = 1'b0;
            st_nxt.flags[c].toff_max_warn    = 1'b0;
         end

         // limits compare as whole amperes; fractions truncate
         // suppression uses the registered ramp flag, which is updated together with the phase
         if (!st_r.ramping[c] && iout_phase_in[c] > l11_int(st_r.regs[c][3]))
            st_nxt.flags[c].oc_fault = 1'b1;
         if (!st_r.ramping[c] && iout_avg_in[c] > l11_int(st_r.regs[c][4]))
         begin
            st_nxt.flags[c].oc_warn          = 1'b1;
            st_nxt.flags[c].iout_status_word = 1'b1;
         end

         // turn-on time limit counts from ramp start; zero means unlimited
         if (st_r.phase[c] == pmcr_pkg::PH_RISE || st_r.phase[c] == pmcr_pkg::PH_ON)
            if (st_r.regs[c][7][10:0] != 11'h000 && st_r.flags[c].uv_trip &&
                st_r.tmr[c] >= ms_cycles(st_r.regs[c][7]))
               st_nxt.flags[c].ton_max_fault = 1'b1;

         // turn-off limit: watch for output under one eighth of the setpoint
         eighth = vout_setpoint_in[c] >> 3;
         if (st_r.mon_on[c])
         begin
            st_nxt.mon[c] = st_r.mon[c] + 32'h0000_0001;
            if (vout_sense_in[c] <= eighth || st_r.regs[c][10][10:0] == 11'h000 ||
                want_on)
               st_nxt.mon_on[c] = 1'b0;
            else if (st_r.mon[c] >= ms_cycles(st_r.regs[c][10]))
            begin
               st_nxt.flags[c].toff_max_warn = 1'b1;
               st_nxt.mon_on[c] = 1'b0;
            end
         end

         // alert is a level rebuilt each cycle from sticky flags and mask
         st_nxt.flags[c].alert = !alert_mask_in[c] &&
            (st_nxt.flags[c].oc_warn || st_nxt.flags[c].oc_fault ||
             st_nxt.flags[c].ton_max_fault || st_nxt.flags[c].toff_max_warn);
      end
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   // synchronous reset; every slot of both copies takes its default
   always_ff @(posedge core_clk_in)
   begin
      if (!nrst_in)
      begin
         st_r <= '0;
         for (int c = 0; c < 2; c++)
            for (int s = 0; s < `PMCR_NUM_CMD; s++)
               st_r.regs[c][s] <= reset_of(s);
      end
      else
         st_r <= st_nxt;
   end

   // the slew limiter itself lives in the setpoint path; rate is exported through reads
   assign rsp_valid_out     = st_r.rsp.valid;
   assign rsp_data_out      = st_r.rsp.data;
   assign cml_fault_out     = st_r.rsp.cml_fault;
   assign run_pull_low_out  = st_r.run_hold;
   assign ramping_out       = st_r.ramping;
   assign lse_out           = st_r.load_step_emulation;
   assign flags_out         = st_r.flags;

   // the stage is driven from ramp start until the fall completes
   always_comb
   begin
      for (int c = 0; c < 2; c++)
         output_enable_out[c] = st_r.phase[c] == pmcr_pkg::PH_RISE ||
                                st_r.phase[c] == pmcr_pkg::PH_ON ||
                                st_r.phase[c] == pmcr_pkg::PH_OFF_DLY ||
                                st_r.phase[c] == pmcr_pkg::PH_FALL;
   end

endmodule

// File: test/pmcr_bank_properties.sv
// port-level concurrent checks of the paged command bank
`timescale 1ns/100ps
`include "pmcr_consts.svh"
module pmcr_bank_properties
(
   input  wire logic                     core_clk_in,
   input  wire logic                     nrst_in,
   input  wire logic                     page_in,
   input  wire pmcr_pkg::pmcr_cmd_t      cmd_in,
   input  wire logic [1:0]               power_good_in,
   input  wire logic [1:0]               alert_mask_in,
   input  wire logic                     rsp_valid_out,
   input  wire logic                     cml_fault_out,
   input  wire logic [1:0]               run_pull_low_out,
   input  wire logic [1:0]               ramping_out,
   input  wire logic [1:0]               output_enable_out,
   input  wire pmcr_pkg::pmcr_lse_t [1:0]   lse_out,
   input  wire pmcr_pkg::pmcr_flags_t [1:0] flags_out
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!nrst_in);
   // ------
   // step sequences
   // ------
   sequence s_lse_static_wr;
      cmd_in.wr && cmd_in.code == `PMCR_OFS_LSE && !page_in && !cmd_in.data[`PMCR_LSE_MODE_BIT];
   endsequence
   sequence s_warn_unmasked;
      flags_out[0].oc_warn && !alert_mask_in[0];
   endsequence
   a_read_answer: assert property (
      cmd_in.rd && cmd_in.code == `PMCR_OFS_OC_FAULT |=> rsp_valid_out && !cml_fault_out)
      else $error("read of a mapped word not answered");
   a_valid_needs_read: assert property (!cmd_in.rd |=> !rsp_valid_out)
      else $error("answer without a read");
   a_ro_write_cml: assert property (
      cmd_in.wr && cmd_in.code == `PMCR_OFS_OFFSET_RB |=> cml_fault_out && !rsp_valid_out)
      else $error("write to readback byte not refused");
   a_gain_on_cml: assert property (
      cmd_in.wr && cmd_in.code == `PMCR_OFS_CAL_GAIN && output_enable_out != 2'h0 |=> cml_fault_out)
      else $error("gain write while running not flagged");
   a_static_level: assert property (
      s_lse_static_wr |-> ##2 (lse_out[0].lse_mag == $past(cmd_in.data[1:0], 2)
         && lse_out[0].lse_active == |$past(cmd_in.data[1:0], 2)))
      else $error("static step does not follow written magnitude");
   a_trig_pulse: assert property (lse_out[0].lse_trigger |=> !lse_out[0].lse_trigger)
      else $error("scope trigger longer than one cycle");
   a_trig_needs_pg: assert property (
      lse_out[0].lse_trigger |-> !$past(power_good_in[0]) || !$past(power_good_in[0], 2))
      else $error("scope trigger without power good fall");
   a_warn_status: assert property (flags_out[0].oc_warn |-> flags_out[0].iout_status_word)
      else $error("warning without status word bit");
   a_alert_unmasked: assert property (s_warn_unmasked ##1 s_warn_unmasked |-> flags_out[0].alert)
      else $error("unmasked warning without alert");
   a_no_oc_ramp: assert property (
      ramping_out[0] [*3] |-> !$rose(flags_out[0].oc_fault) && !$rose(flags_out[0].oc_warn))
      else $error("overcurrent flagged during a ramp");
   a_holdoff_min: assert property ($rose(run_pull_low_out[0]) |-> run_pull_low_out[0] [*8])
      else $error("run hold-off too short");
endmodule
bind pmcr_bank pmcr_bank_properties i_pmcr_bank_properties
(
   .core_clk_in(core_clk_in), .nrst_in(nrst_in), .page_in(page_in), .cmd_in(cmd_in),
   .power_good_in(power_good_in), .alert_mask_in(alert_mask_in),
   .rsp_valid_out(rsp_valid_out), .cml_fault_out(cml_fault_out),
   .run_pull_low_out(run_pull_low_out), .ramping_out(ramping_out),
   .output_enable_out(output_enable_out), .lse_out(lse_out), .flags_out(flags_out)
);

// File: test/pmcr_host_model.sv
// host model that issues paged commands and collects the answers
`timescale 1ns/100ps
module pmcr_host_model
(
   input  wire logic           core_clk_in,
   input  wire logic           rsp_valid_in,
   input  wire logic [15:0]    rsp_data_in,
   input  wire logic           cml_fault_in,
   output logic                page_out,
   output pmcr_pkg::pmcr_cmd_t cmd_out
);
   initial
   begin
      page_out = 1'b0;
      cmd_out = '0;
   end
   // idle fields carry inverted junk so the bank cannot lean on stale values
   task automatic xfer(input logic pg, input logic is_wr, input logic [7:0] c,
                       input logic [15:0] d, output logic [15:0] q, output logic f,
                       output logic v);
      @(posedge core_clk_in);
      page_out <= pg;
      cmd_out <= '{wr: is_wr, rd: !is_wr, code: c, data: d};
      @(posedge core_clk_in);
      cmd_out <= '{wr: 1'b0, rd: 1'b0, code: ~c, data: ~d};
      #1;
      q = rsp_data_in;
      f = cml_fault_in;
      v = rsp_valid_in;
   endtask
endmodule

// File: test/pmbus_current_limit_ramp_cmds_bench.sv
// self-checking bench of the paged command bank
`timescale 1ns/100ps
`include "pmcr_consts.svh"
module pmbus_current_limit_ramp_cmds_bench;
   localparam int T = `PMCR_MS_CYC / 16;
   logic                        core_clk_in, nrst_in, page_in, rsp_valid_out, cml_fault_out;
   pmcr_pkg::pmcr_cmd_t         cmd_in;
   logic [1:0]                  run_pin_in, op_on_in, power_good_in, alert_mask_in;
   logic [1:0]                  status_clear_in, run_pull_low_out, ramping_out, output_enable_out;
   logic [1:0][15:0]            vout_sense_in, vout_setpoint_in, iout_phase_in, iout_avg_in;
   logic [1:0][7:0]             serial_offset_code_in;
   logic [15:0]                 rsp_data_out;
   pmcr_pkg::pmcr_lse_t [1:0]   lse_out;
   pmcr_pkg::pmcr_flags_t [1:0] flags_out;
   int                          n_errors, checks, n;
   pmcr_bank i_pmcr_bank (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .page_in(page_in),
      .cmd_in(cmd_in), .run_pin_in(run_pin_in), .op_on_in(op_on_in),
      .vout_sense_in(vout_sense_in), .vout_setpoint_in(vout_setpoint_in),
      .iout_phase_in(iout_phase_in), .iout_avg_in(iout_avg_in), .power_good_in(power_good_in),
      .serial_offset_code_in(serial_offset_code_in), .alert_mask_in(alert_mask_in),
      .status_clear_in(status_clear_in), .rsp_valid_out(rsp_valid_out),
      .rsp_data_out(rsp_data_out), .cml_fault_out(cml_fault_out),
      .run_pull_low_out(run_pull_low_out), .ramping_out(ramping_out),
      .output_enable_out(output_enable_out), .lse_out(lse_out), .flags_out(flags_out));
   pmcr_host_model i_pmcr_host_model (.core_clk_in(core_clk_in), .rsp_valid_in(rsp_valid_out),
      .rsp_data_in(rsp_data_out), .cml_fault_in(cml_fault_out), .page_out(page_in),
      .cmd_out(cmd_in));
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   function automatic logic [17:0] near(input int v, input int t);
      return {17'h0, v >= t - 4 && v <= t + 4};
   endfunction
   // sel 0: ramping, 1: run hold-off, 2: emulated step; edges counted until lvl shows
   task automatic wait_for(input int sel, input logic lvl, output int cnt);
      logic s;
      cnt = 0;
      do
      begin
         @(posedge core_clk_in);
         #1;
         cnt++;
         s = sel == 0 ? ramping_out[0] : sel == 1 ? run_pull_low_out[0] : lse_out[0].lse_active;
         if (cnt > 4 * T)
         begin
            n_errors++;
            end_of_test();
         end
      end
      while (s !== lvl);
   endtask
   task automatic wr(input logic pg, input logic [7:0] c, input logic [15:0] d, input logic e);
      logic [15:0] q;
      logic        f, v;
      i_pmcr_host_model.xfer(pg, 1'b1, c, d, q, f, v);
      check({v, f, 16'h0000}, {1'b0, e, 16'h0000});
   endtask
   task automatic rd(input logic pg, input logic [7:0] c, input logic [15:0] e);
      logic [15:0] q;
      logic        f, v;
      i_pmcr_host_model.xfer(pg, 1'b0, c, 16'h0000, q, f, v);
      check({v, f, q}, {2'b10, e});
   endtask
   task automatic t_defaults;
      logic [23:0] tbl [13] = '{24'h2782BF, 24'h38CA80, 24'h4405C3, 24'h46DBB8, 24'h4ADA80,
         24'h608000, 24'h61D200, 24'h62D280, 24'h648000, 24'h65D200, 24'h668000,
         24'hDCFBE8, 24'hF70000};
      for (int p = 0; p < 2; p++)
         foreach (tbl[i])
            rd(p[0], tbl[i][23:16], tbl[i][15:0]);
      rd(1'b1, 8'hE8, 16'h00A5);
      wr(1'b0, 8'hE8, 16'h0011, 1'b1);
      rd(1'b0, 8'hE8, 16'h005A);
      wr(1'b0, 8'h00, 16'h0000, 1'b1);
   endtask
   task automatic t_paging;
      wr(1'b1, 8'h4A, 16'hD300, 1'b0);
      rd(1'b0, 8'h4A, 16'hDA80);
      rd(1'b1, 8'h4A, 16'hD300);
   endtask
   task automatic t_lse;
      for (int m = 3; m >= 0; m--)
      begin
         wr(1'b0, 8'hF7, 16'(m), 1'b0);
         repeat (2) @(posedge core_clk_in);
         #1;
         check({14'h0, lse_out[0].lse_active, lse_out[0].lse_mag, lse_out[1].lse_active},
               {14'h0, m != 0, 2'(m), 1'b0});
      end
      wr(1'b0, 8'hF7, 16'h000E, 1'b0);
      wait_for(2, 1'b1, n);
      check({17'h0, n <= 4}, 18'h1);
      wait_for(2, 1'b0, n);
      check(near(n, `PMCR_LSE_PULSE_CYC), 18'h1);
      @(posedge core_clk_in);
      power_good_in[0] <= 1'b0;
      n = 0;
      for (int i = 0; i < 5; i++)
      begin
         @(posedge core_clk_in);
         #1;
         n += lse_out[0].lse_trigger;
      end
      check(18'(n), 18'h1);
      wr(1'b0, 8'hF7, 16'h0000, 1'b0);
   endtask
   task automatic t_seq;
      logic [7:0] ofs [5] = '{8'h60, 8'h61, 8'h64, 8'h65, 8'hDC};
      foreach (ofs[i])
         wr(1'b0, ofs[i], 16'hE001, 1'b0);
      wr(1'b0, 8'h62, 16'h0000, 1'b0);
      wr(1'b0, 8'h38, 16'hCA80, 1'b0);
      @(posedge core_clk_in);
      run_pin_in[0] <= 1'b1;
      op_on_in[0] <= 1'b1;
      wait_for(0, 1'b1, n);
      check(near(n, T), 18'h1);
      iout_phase_in[0] <= 16'd35;
      iout_avg_in[0] <= 16'd25;
      wait_for(0, 1'b0, n);
      check(near(n, T), 18'h1);
      check({16'h0, flags_out[0].oc_fault, flags_out[0].oc_warn}, 18'h0);
      repeat (3) @(posedge core_clk_in);
      #1;
      check({14'h0, flags_out[0].oc_fault, flags_out[0].oc_warn,
             flags_out[0].iout_status_word, flags_out[0].alert}, 18'hF);
      check({17'h0, output_enable_out[0]}, 18'h1);
      wr(1'b1, 8'h38, 16'hCA80, 1'b1);
      @(posedge core_clk_in);
      status_clear_in[0] <= 1'b1;
      iout_phase_in[0] <= 16'd25;
      iout_avg_in[0] <= 16'd10;
      @(posedge core_clk_in);
      status_clear_in[0] <= 1'b0;
      alert_mask_in[0] <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      #1;
      check({16'h0, flags_out[0].oc_fault, flags_out[0].oc_warn}, 18'h0);
      @(posedge core_clk_in);
      iout_avg_in[0] <= 16'd21;
      repeat (3) @(posedge core_clk_in);
      #1;
      check({15'h0, flags_out[0].oc_warn, flags_out[0].iout_status_word,
             flags_out[0].alert}, 18'h6);
      @(posedge core_clk_in);
      iout_avg_in[0] <= 16'd0;
      run_pin_in[0] <= 1'b0;
      wait_for(0, 1'b1, n);
      check(near(n, T), 18'h1);
      wait_for(0, 1'b0, n);
      check(near(n, T), 18'h1);
      wait_for(1, 1'b1, n);
      check({17'h0, n <= 4}, 18'h1);
      wait_for(1, 1'b0, n);
      check(near(n, T), 18'h1);
      check({17'h0, flags_out[0].uv_trip}, 18'h0);
      @(posedge core_clk_in);
      vout_sense_in[0] <= `PMCR_RST_UV_FAULT;
      repeat (2) @(posedge core_clk_in);
      #1;
      check({17'h0, flags_out[0].uv_trip}, 18'h1);
   endtask
   initial
   begin
      core_clk_in = 1'b0;
      forever #10 core_clk_in = ~core_clk_in;
   end
   initial
   begin
      n_errors = 0;
      checks = 0;
      nrst_in = 1'b0;
      run_pin_in = 2'h0;
      op_on_in = 2'h0;
      vout_sense_in = {2{16'h0FFF}};
      vout_setpoint_in = {2{16'h0800}};
      iout_phase_in = '0;
      iout_avg_in = '0;
      power_good_in = 2'h3;
      serial_offset_code_in = {8'hA5, 8'h5A};
      alert_mask_in = 2'h0;
      status_clear_in = 2'h0;
      repeat (5) @(posedge core_clk_in);
      nrst_in <= 1'b1;
      t_defaults();
      t_paging();
      t_lse();
      t_seq();
      end_of_test();
   end
endmodule
